// ==== hdl/ctu_pkg.sv ====
// package of constants and types for the charge time unit edge control block
package ctu_pkg;
    // register byte offsets on the axi4-lite bus
    localparam logic [4:0] ADDR_CURRENT   = 5'h00; // current_source_control
    localparam logic [4:0] ADDR_EDGE      = 5'h04; // edge_channel_control
    localparam logic [4:0] ADDR_HIGH      = 5'h08; // unit_control_high
    localparam logic [4:0] ADDR_IRQ_STAT  = 5'h0C; // sticky event status
    localparam logic [4:0] ADDR_IRQ_MASK  = 5'h10; // interrupt mask
    // field positions in current_source_control
    localparam int RANGE_LSB = 0;
    localparam int TRIM_LSB  = 2;
    // field positions in edge_channel_control
    localparam int FLAG_A_BIT  = 0;
    localparam int FLAG_B_BIT  = 1;
    localparam int SEL_A_LSB   = 2;
    localparam int POL_A_BIT   = 4;
    localparam int SEL_B_LSB   = 5;
    localparam int POL_B_BIT   = 7;
    // field position in unit_control_high
    localparam int ORDER_BIT   = 2;
    // reset values
    localparam logic [7:0] CURRENT_RST = 8'h00;
    localparam logic [7:0] EDGE_RST    = 8'h00;
    localparam logic [7:0] HIGH_RST    = 8'h00;
    // range encodings; 01 is the smallest current range
    localparam logic [1:0] RANGE_SMALL = 2'h1;
    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // source selector codes
    localparam logic [1:0] SRC_PIN_A   = 2'h0;
    localparam logic [1:0] SRC_PIN_B   = 2'h1;
    localparam logic [1:0] SRC_TRIG_1  = 2'h2;
    localparam logic [1:0] SRC_TRIG_2  = 2'h3;

    // raw edge sources from outside
    typedef struct packed {
        logic edge_pin_a;
        logic edge_pin_b;
        logic trig_one;   // enhanced_compare_unit_one trigger
        logic trig_two;   // compare_unit_two trigger
    } ctu_src_s;

    // analogue side settings
    typedef struct packed {
        logic [5:0] current_trim;
        logic [1:0] current_range_sel;
        logic       source_enable;
    } ctu_ana_s;

    // bus slave states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_RESP = 2'b01
    } ctu_bus_e;
endpackage

// ==== hdl/ctu_edge_ctrl.sv ====
// edge gated current source control with axi4-lite register slave
`timescale 1ns/1ps
// Summary of operation
// - two-bit range select, 01 is smallest
// - six-bit signed trim in bits seven:two
// - each channel selects pin or compare trigger
// - channels sense level, not transition
// - polarity bits seven and four per channel
// - ordering enable: second waits for first
// - channel event sets its status flag
// - config change matching level sets flag
// - source on when exactly one flag set
// - software may write flags, same gating
//
// notes for whoever picks this up next:
// - channel inputs are level compares; a config write that already matches
//   the pin level sets the flag in the same cycle the write executes
// - a hardware set always beats a software clear landing in the same cycle,
//   so a clear racing a live level is lost; software must quiet the source first
// - the ordering filter sees channel a's set from this very cycle, so both
//   channels going active together still gives a complete measurement
// - the source enable is a registered xor of the flags, in step with them;
//   the converter sees a gate window exactly as long as the flag interval
// - only the low write strobe matters, no register is wider than one byte
// - one write and one read at a time; the ready lines drop while a half waits
module ctu_edge_ctrl
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [4:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [4:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire ctu_pkg::ctu_src_s src,
    output ctu_pkg::ctu_ana_s      ana,
    output logic                   irq
);

    // whole module state in one record
    typedef struct packed {
        logic [7:0]        cur;      // current_source_control
        logic [7:0]        edg;      // edge_channel_control
        logic [7:0]        hi;       // unit_control_high
        logic [1:0]        stat;     // sticky event bits, a and b
        logic [1:0]        mask;     // interrupt mask
        logic              aw_got;   // write address held
        logic              w_got;    // write data held
        logic [4:0]        aw_addr;
        logic [31:0]       w_data;
        logic [3:0]        w_strb;
        ctu_pkg::ctu_bus_e wst;      // write channel state
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic              irq;
        ctu_pkg::ctu_ana_s ana;
    } ctu_state_s;

    ctu_state_s st_reg;   // registered state
    ctu_state_s st_next;  // next state

    // select one of four sources by code
    function automatic logic pick(input logic [1:0] sel, input ctu_pkg::ctu_src_s s);
        logic v;
        v = 1'b0;
        case (sel)
            ctu_pkg::SRC_PIN_A:  v = s.edge_pin_a;
            ctu_pkg::SRC_PIN_B:  v = s.edge_pin_b;
            ctu_pkg::SRC_TRIG_1: v = s.trig_one;
            ctu_pkg::SRC_TRIG_2: v = s.trig_two;
            default:             v = 1'b0;
        endcase
        return v;
    endfunction

    logic       lvl_a;     // channel a selected source level
    logic       lvl_b;     // channel b selected source level
    logic       hit_a;     // channel a active per polarity
    logic       hit_b;     // channel b active per polarity
    logic       wr_fire;   // both write halves present
    logic [7:0] wbyte;     // low byte of write data
    logic [7:0] edg_cfg;   // edge register after this write
    logic [1:0] flags;     // flags after software and hardware
    logic       flag_a_q;  // channel a flag as registered
    logic       flag_b_q;  // channel b flag as registered
    logic       edge_wr;   // write to the edge register executes now
    logic       order_on;  // ordering filter enabled

    // channel inputs use the config in force this cycle
    always_comb
    begin
        wr_fire = st_reg.aw_got && st_reg.w_got && (st_reg.wst == ctu_pkg::BUS_IDLE);
        wbyte   = st_reg.w_data[7:0];
        // registered views used by the checks below
        flag_a_q = st_reg.edg[ctu_pkg::FLAG_A_BIT];
        flag_b_q = st_reg.edg[ctu_pkg::FLAG_B_BIT];
        order_on = st_reg.hi[ctu_pkg::ORDER_BIT];
        edge_wr  = wr_fire && st_reg.w_strb[0] && (st_reg.aw_addr == ctu_pkg::ADDR_EDGE);
        // new config applies at once, so a write that matches the level sets the flag
        edg_cfg = st_reg.edg;
        if (wr_fire && st_reg.w_strb[0] && st_reg.aw_addr == ctu_pkg::ADDR_EDGE)
        begin
            edg_cfg = wbyte;
        end
        lvl_a = pick(edg_cfg[ctu_pkg::SEL_A_LSB +: 2], src);
        lvl_b = pick(edg_cfg[ctu_pkg::SEL_B_LSB +: 2], src);
        // level compare, not an edge detector
        hit_a = (lvl_a == edg_cfg[ctu_pkg::POL_A_BIT]);
        hit_b = (lvl_b == edg_cfg[ctu_pkg::POL_B_BIT]);
        flags = {edg_cfg[ctu_pkg::FLAG_B_BIT], edg_cfg[ctu_pkg::FLAG_A_BIT]};
        // hardware sets win over a software clear in the same cycle
        if (hit_a)
        begin
            flags[0] = 1'b1;
        end
        // ordering filter looks at channel a including this cycle's set
        if (hit_b && (!st_reg.hi[ctu_pkg::ORDER_BIT] || flags[0]))
        begin
            flags[1] = 1'b1;
        end
    end

    // next state of registers, bus and outputs
    always_comb
    begin
        st_next = st_reg;
        // write address and data taken in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            st_next.aw_got  = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            st_next.w_got  = 1'b1;
            st_next.w_data = s_axi_wdata;
            st_next.w_strb = s_axi_wstrb;
        end
        // flags are sticky; only a write clears them
        st_next.edg = {edg_cfg[7:2], flags};
        // new flag rises feed the interrupt status
        st_next.stat = st_reg.stat | (flags & ~st_reg.edg[1:0]);
        if (wr_fire)
        begin
            st_next.aw_got = 1'b0;
            st_next.w_got  = 1'b0;
            st_next.wst    = ctu_pkg::BUS_RESP;
            st_next.bvalid = 1'b1;
            st_next.bresp  = ctu_pkg::RESP_OKAY;
            if (st_reg.w_strb[0])
            begin
                case (st_reg.aw_addr)
                    ctu_pkg::ADDR_CURRENT:  st_next.cur = wbyte;
                    ctu_pkg::ADDR_EDGE:     ;                          // applied above
                    ctu_pkg::ADDR_HIGH:     st_next.hi = wbyte;
                    ctu_pkg::ADDR_IRQ_STAT: st_next.stat = (st_reg.stat & ~wbyte[1:0])
                                                | (flags & ~st_reg.edg[1:0]);
                    ctu_pkg::ADDR_IRQ_MASK: st_next.mask = wbyte[1:0];
                    default:                st_next.bresp = ctu_pkg::RESP_SLVERR;
                endcase
            end
            else if (st_reg.aw_addr > ctu_pkg::ADDR_IRQ_MASK || st_reg.aw_addr[1:0] != 2'h0)
            begin
                st_next.bresp = ctu_pkg::RESP_SLVERR;
            end
        end
        // write response held until taken
        if (st_reg.bvalid && s_axi_bready)
        begin
            st_next.bvalid = 1'b0;
            st_next.wst    = ctu_pkg::BUS_IDLE;
        end
        // read: one cycle accept, data the next
        st_next.arready = 1'b0;
        if (s_axi_arvalid && st_reg.arready)
        begin
            st_next.rvalid = 1'b1;
            st_next.rresp  = ctu_pkg::RESP_OKAY;
            case (s_axi_araddr)
                ctu_pkg::ADDR_CURRENT:  st_next.rdata = {24'h000000, st_reg.cur};
                ctu_pkg::ADDR_EDGE:     st_next.rdata = {24'h000000, st_reg.edg};
                ctu_pkg::ADDR_HIGH:     st_next.rdata = {24'h000000, st_reg.hi};
                ctu_pkg::ADDR_IRQ_STAT: st_next.rdata = {30'h00000000, st_reg.stat};
                ctu_pkg::ADDR_IRQ_MASK: st_next.rdata = {30'h00000000, st_reg.mask};
                default:
                begin
                    st_next.rdata = 32'h00000000;
                    st_next.rresp = ctu_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (!st_reg.rvalid && !(st_reg.rvalid && s_axi_rready))
        begin
            st_next.arready = 1'b1;
        end
        if (st_reg.rvalid && s_axi_rready)
        begin
            st_next.rvalid = 1'b0;
        end
        // source on only between the two edges
        st_next.ana.source_enable     = st_next.edg[0] ^ st_next.edg[1];
        st_next.ana.current_range_sel = st_next.cur[ctu_pkg::RANGE_LSB +: 2];
        st_next.ana.current_trim      = st_next.cur[ctu_pkg::TRIM_LSB +: 6];
        st_next.irq                   = |(st_next.stat & st_next.mask);
    end

    // single register stage, synchronous reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_reg      <= '0;
            st_reg.cur  <= ctu_pkg::CURRENT_RST;
            st_reg.edg  <= ctu_pkg::EDGE_RST;
            st_reg.hi   <= ctu_pkg::HIGH_RST;
            st_reg.wst  <= ctu_pkg::BUS_IDLE;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ports straight from flops except the write readies, decoded with reset; address channels free only when idle
    assign s_axi_awready = !st_reg.aw_got && (st_reg.wst == ctu_pkg::BUS_IDLE) && aresetn;
    assign s_axi_wready  = !st_reg.w_got && (st_reg.wst == ctu_pkg::BUS_IDLE) && aresetn;
    assign s_axi_bvalid  = st_reg.bvalid;
    assign s_axi_bresp   = st_reg.bresp;
    assign s_axi_arready = st_reg.arready;
    assign s_axi_rvalid  = st_reg.rvalid;
    assign s_axi_rdata   = st_reg.rdata;
    assign s_axi_rresp   = st_reg.rresp;
    assign ana           = st_reg.ana;
    assign irq           = st_reg.irq;

    // enable matches the flag xor in the same cycle
    a_enable_xor: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> ana.source_enable == (flag_a_q ^ flag_b_q))
        else $error("source enable not xor of flags");

    // active channel a sets its flag next cycle
    a_flag_a_set: assert property (@(posedge aclk) disable iff (!aresetn)
        hit_a |=> flag_a_q)
        else $error("channel a event lost");

    // ordered mode never sets b alone from hardware
    a_order_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (order_on && !flags[0] && !edge_wr) |=> !($rose(flag_b_q) && !flag_a_q))
        else $error("channel b accepted before a");

    // flag stays without a write to it
    a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        (flag_a_q && !(wr_fire && st_reg.aw_addr == ctu_pkg::ADDR_EDGE)) |=> flag_a_q)
        else $error("flag dropped without write");

    // range output mirrors register
    a_range_out: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 ana.current_range_sel == st_reg.cur[ctu_pkg::RANGE_LSB +: 2])
        else $error("range output wrong");

    // trim output mirrors register
    a_trim_out: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 ana.current_trim == st_reg.cur[ctu_pkg::TRIM_LSB +: 6])
        else $error("trim output wrong");

    // matching level with b picked sets flag b when unordered
    a_level_b: assert property (@(posedge aclk) disable iff (!aresetn)
        (hit_b && !order_on) |=> flag_b_q)
        else $error("channel b level ignored");

    // a software write of flags lands the next cycle
    a_sw_flags: assert property (@(posedge aclk) disable iff (!aresetn)
        (edge_wr && !hit_a && !hit_b) |=> {flag_b_q, flag_a_q}
            == $past({st_reg.w_data[ctu_pkg::FLAG_B_BIT], st_reg.w_data[ctu_pkg::FLAG_A_BIT]}))
        else $error("software flag write lost");

    // b flag sticky as well, only a write drops it
    a_flag_b_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        (flag_b_q && !edge_wr) |=> flag_b_q)
        else $error("flag b dropped without write");

    // ordered mode takes b once a is already set
    a_order_b_set: assert property (@(posedge aclk) disable iff (!aresetn)
        (hit_b && order_on && flag_a_q && !wr_fire) |=> flag_b_q)
        else $error("channel b refused after a");

    // both flags set: current source off
    a_both_off: assert property (@(posedge aclk) disable iff (!aresetn)
        (flag_a_q && flag_b_q) |-> !ana.source_enable)
        else $error("source on with both flags");

    // no flag set: current source off
    a_none_off: assert property (@(posedge aclk) disable iff (!aresetn)
        (!flag_a_q && !flag_b_q) |-> !ana.source_enable)
        else $error("source on with no flag");

    // exactly one flag: current source on
    a_one_on: assert property (@(posedge aclk) disable iff (!aresetn)
        (flag_a_q ^ flag_b_q) |-> ana.source_enable)
        else $error("source off with one flag");

    // config write that matches the level sets flag a
    a_cfg_match: assert property (@(posedge aclk) disable iff (!aresetn)
        (edge_wr && hit_a) |=> flag_a_q)
        else $error("config match did not set flag");

    // current register takes the written byte
    a_cur_write: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && st_reg.w_strb[0] && st_reg.aw_addr == ctu_pkg::ADDR_CURRENT)
        |=> st_reg.cur == $past(st_reg.w_data[7:0]))
        else $error("current register write lost");

    // write response stands until taken
    a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
        else $error("write response dropped early");

    // read response stands until taken
    a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid)
        else $error("read response dropped early");

    // read data stays put while it waits
    a_rdata_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_rvalid && !s_axi_rready) |=> $stable(s_axi_rdata))
        else $error("read data changed while waiting");

    // interrupt is high exactly while an unmasked status bit is set
    a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |-> irq == |(st_reg.stat & st_reg.mask))
        else $error("interrupt level wrong");
endmodule

// ==== tb/ctu_far_model.sv ====
// far side model: edge sources and a converter that integrates charge
`timescale 1ns/1ps
module ctu_far_model
(
    input  wire logic          aclk,
    input  wire logic [3:0]    lvl,
    input  wire logic          src_on,
    output ctu_pkg::ctu_src_s  src,
    output logic [15:0]        charge
);
    initial charge = 16'h0000;
    // sources follow the command one edge later, like a synced pin
    always_ff @(posedge aclk)
    begin
        src <= lvl;
    end
    // converter counts cycles with current flowing, so the gate window is measurable
    always_ff @(posedge aclk)
    begin
        charge <= charge + {15'h0000, src_on};
    end
endmodule

// ==== tb/ctu_edge_ctrl_tb_top.sv ====
// self-checking bench for the edge gated current control block
`timescale 1ns/1ps
module ctu_edge_ctrl_tb_top;
    logic              aclk = 1'b0;
    logic              aresetn = 1'b0;  // active low
    logic [4:0]        awa = 5'h00, ara = 5'h00;
    logic              awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic [31:0]       wd = 32'h00000000;
    logic              awr, wr_rdy, bv, arr, rv, irq;
    logic [1:0]        bresp, rresp, rs;
    logic [31:0]       rdata, rd;
    logic [3:0]        lvl = 4'hF;  // pins high keep reset config idle
    logic [15:0]       charge, c0;
    ctu_pkg::ctu_src_s src;
    ctu_pkg::ctu_ana_s ana;
    int                mismatches = 0;
    int                tests_run = 0;

    always #12.5 aclk = ~aclk;  // 40 MHz

    ctu_edge_ctrl u_ctu_edge_ctrl (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .src(src), .ana(ana), .irq(irq));
    ctu_far_model u_ctu_far_model (.aclk(aclk), .lvl(lvl), .src_on(ana.source_enable),
        .src(src), .charge(charge));

    // single compare point, counts every check
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // write: both halves offered together, each dropped when taken
    // handshakes judged at the falling edge, as they will stand at the next rise
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic aw_t, w_t, b_t;
        @(posedge aclk);
        awa <= a;
        wd <= {24'h000000, d};
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        b_t = 1'b0;
        while (!b_t)
        begin
            @(negedge aclk);
            aw_t = awv && awr;
            w_t = wv && wr_rdy;
            b_t = bv;
            rs = bresp;
            @(posedge aclk);
            if (aw_t)
                awv <= 1'b0;
            if (w_t)
                wv <= 1'b0;
        end
        br <= 1'b0;
    endtask
    task automatic rdr(input logic [4:0] a);
        logic ar_t, r_t;
        @(posedge aclk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        r_t = 1'b0;
        while (!r_t)
        begin
            @(negedge aclk);
            ar_t = arv && arr;
            r_t = rv;
            rd = rdata;
            rs = rresp;
            @(posedge aclk);
            if (ar_t)
                arv <= 1'b0;
        end
        rr <= 1'b0;
    endtask
    function automatic logic [7:0] ec(logic pb, logic [1:0] sb, logic pa, logic [1:0] sa,
                                      logic [1:0] f);
        return {pb, sb, pa, sa, f};
    endfunction
    task automatic chkf(input logic [1:0] f);
        rdr(ctu_pkg::ADDR_EDGE);
        check("status flags", rd[1:0], f);
    endtask
    // write twice: first edge may still see the old config match
    task automatic arm(input logic [7:0] cfg);
        wr(ctu_pkg::ADDR_EDGE, cfg);
        wr(ctu_pkg::ADDR_EDGE, cfg);
        wr(ctu_pkg::ADDR_IRQ_STAT, 8'h03);
        wt(3);
    endtask
    task automatic t_rst;
        for (int i = 0; i < 5; i++)
        begin
            rdr(5'(4 * i));
            check("reset value", rd, 32'h00000000);
        end
        check("reset ana", ana, 9'h000);
    endtask
    task automatic t_cur;
        logic [7:0] tv[3] = '{8'h7D, 8'h85, 8'h01};  // max up, max down, smallest range
        foreach (tv[i])
        begin
            wr(ctu_pkg::ADDR_CURRENT, tv[i]);
            wt(2);
            check("range", ana.current_range_sel, tv[i][1:0]);
            check("trim", ana.current_trim, tv[i][7:2]);
            rdr(ctu_pkg::ADDR_CURRENT);
            check("current reg", rd, {24'h000000, tv[i]});
        end
    endtask
    // a high, later b high: current flows exactly between the two
    task automatic t_meas;
        lvl <= 4'h0;
        wr(ctu_pkg::ADDR_IRQ_MASK, 8'h03);
        arm(ec(1'b1, ctu_pkg::SRC_PIN_B, 1'b1, ctu_pkg::SRC_PIN_A, 2'h0));
        c0 = charge;
        lvl[3] <= 1'b1;
        wt(4);
        check("source on", ana.source_enable, 1'b1);
        check("irq", irq, 1'b1);
        lvl[3] <= 1'b0;
        wt(6);
        lvl[2] <= 1'b1;
        wt(5);
        check("charge", charge - c0, 16'h000A);
        chkf(2'h3);
        lvl <= 4'h0;
        arm(ec(1'b1, ctu_pkg::SRC_PIN_B, 1'b1, ctu_pkg::SRC_PIN_A, 2'h0));
        chkf(2'h0);
        check("irq clear", irq, 1'b0);
    endtask
    // every source code; polarity change alone sets the flag
    task automatic t_cfg;
        for (int s = 0; s < 4; s++)
        begin
            lvl <= 4'h8 >> s;
            arm(ec(1'b1, 2'(s + 1), 1'b0, 2'(s), 2'h0));
            chkf(2'h0);
            wr(ctu_pkg::ADDR_EDGE, ec(1'b1, 2'(s + 1), 1'b1, 2'(s), 2'h0));
            wt(3);
            chkf(2'h1);
        end
    endtask
    task automatic t_ord;
        logic [7:0] cfg = ec(1'b1, ctu_pkg::SRC_PIN_B, 1'b1, ctu_pkg::SRC_PIN_A, 2'h0);
        lvl <= 4'h0;
        wr(ctu_pkg::ADDR_HIGH, 8'h04);
        arm(cfg);
        lvl[2] <= 1'b1;
        wt(5);
        chkf(2'h0);
        lvl[3] <= 1'b1;
        wt(5);
        chkf(2'h3);
        wr(ctu_pkg::ADDR_HIGH, 8'h00);
        wr(ctu_pkg::ADDR_IRQ_MASK, 8'h01);
        lvl <= 4'h0;
        arm(cfg);
        lvl[2] <= 1'b1;
        wt(5);
        chkf(2'h2);
        check("masked irq", irq, 1'b0);
        rdr(ctu_pkg::ADDR_IRQ_STAT);
        check("irq status", rd, 32'h00000002);
        wr(ctu_pkg::ADDR_IRQ_MASK, 8'h03);
        wt(2);
        check("unmasked irq", irq, 1'b1);
        lvl <= 4'h0;
        arm(cfg);
    endtask
    // software sets flags: on only for exactly one
    task automatic t_sw;
        for (int f = 1; f < 5; f++)
        begin
            wr(ctu_pkg::ADDR_EDGE, ec(1'b1, ctu_pkg::SRC_PIN_B, 1'b1, ctu_pkg::SRC_PIN_A, 2'(f)));
            wt(3);
            check("sw gate", ana.source_enable, ^(2'(f)));
        end
        rdr(5'h14);
        check("unmapped read", rs, ctu_pkg::RESP_SLVERR);
        wr(5'h1C, 8'h5A);
        check("unmapped write", rs, ctu_pkg::RESP_SLVERR);
    endtask
    task automatic give_verdict;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // main sequence after an 8 cycle reset
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_rst;
        t_cur;
        t_meas;
        t_cfg;
        t_ord;
        t_sw;
        give_verdict;
    end
    // watchdog: whole run needs well under this many cycles
    initial
    begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        give_verdict;
    end
endmodule
